// file: logic/uv_fault_sequencer.sv
`timescale 1ns/1ps
`include "uv_fault_map.svh"

// Notes on behaviour
// [R01] Retry field bits 5:3 give 0..6 restart attempts; all ones is unlimited.
// [R02] Fault still present after attempts run out: output off until cleared.
// [R03] Latched fault clears on reset, power cycle or bias loss.
// [R04] Restart attempts are spaced by delay time 2 chosen by bits 2:0.
// [R05] After detection, wait delay time 1 from bits 2:0, then disable.
// [R06] Bits 7:6 pick ignore, delayed shutdown, immediate shutdown, wait-clear.
// [R07] Fault declared when measured input falls below threshold register.
// [R08] Remaining-attempt count reloads from retry field whenever no fault is present in the run state.
module uv_fault_sequencer
  import uv_fault_pkg::*;
#(
  parameter int TICK_CYCLES = `UV_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // register access
  input  reg_req_s         reg_req,
  output logic [15:0]      reg_rdata_q,
  // measurement, same clock domain
  input  wire logic [10:0] vin_mant,
  input  wire logic [4:0]  vin_exp,
  // supply pins
  input  wire logic        power_on_pin,
  input  wire logic        bias_ok_pin,
  // status and control
  output logic             out_enable_q,
  output logic             uv_fault_q,
  output logic             fault_latched_q,
  output logic [2:0]       retries_left_q
);

  action_s     action_q;
  logic [10:0] thresh_q;
  seq_state_e  state_q;
  logic [1:0]  pwr_sync_q;
  logic [1:0]  bias_sync_q;
  logic        pwr_prev_q;
  logic        clear_evt;
  logic        retry_ok;
  logic        shut_now;
  logic        tmr_load;
  logic [11:0] tmr_ms;
  logic        tmr_done;
  logic        out_on;
  resp_e       resp;

  function automatic logic [11:0] delay1_ms(input logic [2:0] code);
    delay1_ms = `UV_D1_BASE_MS << code;
  endfunction

  function automatic logic [11:0] delay2_ms(input logic [2:0] code);
    unique case (code)
      3'h0: delay2_ms = `UV_D2_0_MS;
      3'h1: delay2_ms = `UV_D2_1_MS;
      3'h2: delay2_ms = `UV_D2_2_MS;
      3'h3: delay2_ms = `UV_D2_3_MS;
      3'h4: delay2_ms = `UV_D2_4_MS;
      3'h5: delay2_ms = `UV_D2_5_MS;
      3'h6: delay2_ms = `UV_D2_6_MS;
      3'h7: delay2_ms = `UV_D2_7_MS;
    endcase
  endfunction

  // register writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      action_q <= `UV_ACT_RESET;
      thresh_q <= `UV_THR_RESET;
    end else if (reg_req.wr) begin
      if (reg_req.sel == `UV_SEL_ACTION) begin
        action_q <= reg_req.wdata[`UV_RESP_HI:0];
      end else begin
        thresh_q <= reg_req.wdata[`UV_MANT_HI:0];
      end
    end
  end

  // registered read-back; exponent bits are read only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_req.sel == `UV_SEL_ACTION) begin
      reg_rdata_q <= {8'h00, action_q};
    end else begin
      reg_rdata_q <= {vin_exp, thresh_q};
    end
  end

  // supply pins are asynchronous to mclk
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_sync_q  <= 2'b00;
      bias_sync_q <= 2'b00;
      pwr_prev_q  <= 1'b0;
    end else begin
      pwr_sync_q  <= {pwr_sync_q[0], power_on_pin};
      bias_sync_q <= {bias_sync_q[0], bias_ok_pin};
      pwr_prev_q  <= pwr_sync_q[1];
    end
  end

  // power-off edge or missing bias releases a latched fault
  assign clear_evt = (pwr_prev_q && !pwr_sync_q[1]) || !bias_sync_q[1]; // R03

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      uv_fault_q <= 1'b0;
    end else begin
      uv_fault_q <= (vin_mant < thresh_q); // R07
    end
  end

  assign resp     = resp_e'(action_q.resp);
  assign retry_ok = (action_q.retry == `UV_RETRY_INF) ||
                    (retries_left_q != 3'h0); // R01

  // cycle in which the output is dropped and a retry decision is made
  always_comb begin
    shut_now = 1'b0;
    unique case (state_q)
      ST_RUN:    shut_now = uv_fault_q && (resp == RESP_IMMED); // R06
      ST_DELAY1: shut_now = tmr_done && uv_fault_q; // R05
      default:   shut_now = 1'b0;
    endcase
  end

  always_comb begin
    tmr_load = 1'b0;
    tmr_ms   = delay1_ms(action_q.delay);
    if (state_q == ST_RUN && uv_fault_q && resp == RESP_DELAYED) begin
      tmr_load = 1'b1; // R05
    end else if (shut_now && retry_ok) begin
      tmr_load = 1'b1;
      tmr_ms   = delay2_ms(action_q.delay); // R04
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_RUN;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (uv_fault_q) begin
            unique case (resp)
              RESP_IGNORE:   state_q <= ST_RUN; // R06
              RESP_DELAYED:  state_q <= ST_DELAY1;
              RESP_IMMED:    state_q <= retry_ok ? ST_RETRY : ST_LATCH; // R02
              RESP_WAIT_CLR: state_q <= ST_CLRWAIT;
            endcase
          end
        end
        ST_DELAY1: begin
          // fault gone before the delay ran out: keep running
          if (!uv_fault_q) begin
            state_q <= ST_RUN;
          end else if (tmr_done) begin
            state_q <= retry_ok ? ST_RETRY : ST_LATCH; // R02
          end
        end
        ST_RETRY: begin
          if (tmr_done) begin
            state_q <= ST_RUN; // R04
          end
        end
        ST_CLRWAIT: begin
          if (!uv_fault_q) begin
            state_q <= ST_RUN; // R06
          end
        end
        ST_LATCH: begin
          if (clear_evt) begin
            state_q <= ST_RUN; // R03
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // attempts left in this fault episode
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      retries_left_q <= 3'h0;
    end else if (!uv_fault_q && state_q == ST_RUN) begin
      retries_left_q <= action_q.retry; // R08
    end else if (shut_now && action_q.retry != `UV_RETRY_INF &&
                 retries_left_q != 3'h0) begin
      retries_left_q <= retries_left_q - 3'h1; // R01
    end
  end

  assign out_on = (state_q == ST_RUN) || (state_q == ST_DELAY1);

  // supply gating holds the output off while power or bias is absent
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_enable_q    <= 1'b0;
      fault_latched_q <= 1'b0;
    end else begin
      out_enable_q    <= out_on && pwr_sync_q[1] && bias_sync_q[1]; // R02
      fault_latched_q <= (state_q == ST_LATCH); // R02
    end
  end

  ms_delay_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .load    (tmr_load),
    .ms      (tmr_ms),
    .done_q  (tmr_done),
    .busy_q  ()
  );

endmodule

// file: logic/uv_fault_map.svh
`ifndef UV_FAULT_MAP_SVH
`define UV_FAULT_MAP_SVH

// response register field positions
`define UV_RESP_HI       7
`define UV_RESP_LO       6
`define UV_RETRY_HI      5
`define UV_RETRY_LO      3
`define UV_DELAY_HI      2
`define UV_DELAY_LO      0
`define UV_RETRY_INF     3'h7
`define UV_ACT_RESET     8'h00

// threshold register layout
`define UV_MANT_HI       10
`define UV_EXP_W         5
`define UV_THR_RESET     11'h000

// register select codes
`define UV_SEL_ACTION    1'b0
`define UV_SEL_THRESH    1'b1

// timing
`define UV_CLK_NS        50
`define UV_MS_NS         1000000
`define UV_TICK_CYCLES   (`UV_MS_NS / `UV_CLK_NS)

// delay 1 is a base time doubled per code step
`define UV_D1_BASE_MS    12'h00A
// delay 2 table, milliseconds
`define UV_D2_0_MS       12'd252
`define UV_D2_1_MS       12'd558
`define UV_D2_2_MS       12'd924
`define UV_D2_3_MS       12'd1260
`define UV_D2_4_MS       12'd1596
`define UV_D2_5_MS       12'd1932
`define UV_D2_6_MS       12'd2268
`define UV_D2_7_MS       12'd2604

`endif

// file: logic/uv_fault_pkg.sv
package uv_fault_pkg;

  typedef enum logic [1:0] {
    RESP_IGNORE   = 2'b00,
    RESP_DELAYED  = 2'b01,
    RESP_IMMED    = 2'b10,
    RESP_WAIT_CLR = 2'b11
  } resp_e;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_DELAY1  = 3'b001,
    ST_RETRY   = 3'b010,
    ST_CLRWAIT = 3'b011,
    ST_LATCH   = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } action_s;

  typedef struct packed {
    logic        wr;
    logic        sel;
    logic [15:0] wdata;
  } reg_req_s;

endpackage

// file: logic/ms_delay_timer.sv
`timescale 1ns/1ps
`include "uv_fault_map.svh"

// one-shot millisecond timer; a new load restarts it
module ms_delay_timer #(
  parameter int TICK_CYCLES = `UV_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // control
  input  wire logic        load,
  input  wire logic [11:0] ms,
  // status
  output logic             done_q,
  output logic             busy_q
);

  logic [15:0] pre_q;
  logic [11:0] left_q;
  logic        tick;

  assign tick = (pre_q == 16'(TICK_CYCLES - 1));

  // millisecond prescaler, realigned on every load
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= 16'h0000;
    end else if (load || tick) begin
      pre_q <= 16'h0000;
    end else if (busy_q) begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      left_q <= 12'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        left_q <= ms;
        busy_q <= 1'b1;
      end else if (busy_q && tick) begin
        left_q <= left_q - 12'h001;
        if (left_q <= 12'h001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

endmodule

// file: dv/uv_fault_chk_asserts.sv
`timescale 1ns/1ps
module uv_fault_chk
  import uv_fault_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input reg_req_s         reg_req,
  input wire logic [15:0] reg_rdata_q,
  input wire logic [10:0] vin_mant,
  input wire logic [4:0]  vin_exp,
  input wire logic        power_on_pin,
  input wire logic        bias_ok_pin,
  input wire logic        out_enable_q,
  input wire logic        uv_fault_q,
  input wire logic        fault_latched_q,
  input wire logic [2:0]  retries_left_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // four samples cover the two-flop pin synchroniser
  sequence s_pins_ok; (power_on_pin && bias_ok_pin)[*4]; endsequence
  sequence s_thr_quiet; (reg_req.sel && !reg_req.wr)[*3]; endsequence
  sequence s_run_quiet;
    (!reg_req.sel && !reg_req.wr && out_enable_q && !uv_fault_q)[*4];
  endsequence
  property p_latch_off;
    fault_latched_q && $past(fault_latched_q) |-> !out_enable_q;
  endproperty
  property p_latch_hold; s_pins_ok ##0 fault_latched_q |=> fault_latched_q;
  endproperty
  property p_bias_clr;
    fault_latched_q && !bias_ok_pin |-> ##[1:4] !fault_latched_q;
  endproperty
  property p_pins_off; (!power_on_pin)[*4] |-> !out_enable_q; endproperty
  // a reload only happens with no fault, so any change during a fault
  // must be a single decrement
  property p_step;
    $past(uv_fault_q) && retries_left_q != $past(retries_left_q) |->
      retries_left_q == $past(retries_left_q) - 3'h1;
  endproperty
  property p_act_wr; (reg_req.wr && !reg_req.sel) ##1 !reg_req.sel
    |=> reg_rdata_q == {8'h00, $past(reg_req.wdata[7:0], 2)};
  endproperty
  property p_thr_wr; (reg_req.wr && reg_req.sel) ##1 reg_req.sel
    |=> reg_rdata_q[10:0] == $past(reg_req.wdata[10:0], 2);
  endproperty
  property p_cmp;
    s_thr_quiet |-> uv_fault_q == ($past(vin_mant) < reg_rdata_q[10:0]);
  endproperty
  property p_reload;
    s_run_quiet |=> retries_left_q == $past(reg_rdata_q[5:3]);
  endproperty
  a_latch_off: assert property (p_latch_off)
    else $error("output on while latched");
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch released with pins good");
  a_bias_clr: assert property (p_bias_clr)
    else $error("bias loss did not clear latch");
  a_pins_off: assert property (p_pins_off)
    else $error("output on while power off");
  a_step: assert property (p_step)
    else $error("attempt count dropped by more than one");
  a_act_wr: assert property (p_act_wr)
    else $error("action read back wrong");
  a_thr_wr: assert property (p_thr_wr)
    else $error("threshold read back wrong");
  a_cmp: assert property (p_cmp)
    else $error("fault flag disagrees with threshold");
  a_reload: assert property (p_reload)
    else $error("attempt count not reloaded");
endmodule

bind uv_fault_sequencer uv_fault_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req),
  .reg_rdata_q(reg_rdata_q), .vin_mant(vin_mant), .vin_exp(vin_exp),
  .power_on_pin(power_on_pin), .bias_ok_pin(bias_ok_pin),
  .out_enable_q(out_enable_q), .uv_fault_q(uv_fault_q),
  .fault_latched_q(fault_latched_q), .retries_left_q(retries_left_q));

// file: dv/tb_uv_fault_sequencer.sv
`timescale 1ns/1ps
module tb_uv_fault_sequencer;
  import uv_fault_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  reg_req_s    reg_req = '0;
  logic [15:0] rdata;
  logic [10:0] vin_mant = 11'h0C8;
  logic [4:0]  vin_exp = 5'h05;
  logic        pwr = 1'b1;
  logic        bias = 1'b1;
  logic        oe, uv, lat;
  logic [2:0]  left;
  int          n_errors = 0;
  int          checks = 0;
  int          n;

  // tick of 4 cycles per ms keeps delay 2 code 0 near a thousand cycles
  uv_fault_sequencer #(.TICK_CYCLES(4)) i_uv_fault_sequencer (
    .mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata_q(rdata), .vin_mant(vin_mant), .vin_exp(vin_exp),
    .power_on_pin(pwr), .bias_ok_pin(bias), .out_enable_q(oe),
    .uv_fault_q(uv), .fault_latched_q(lat), .retries_left_q(left));

  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic wr(input logic s, input logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, sel: s, wdata: d};
    @(posedge mclk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic s, input logic [15:0] e);
    @(posedge mclk);
    reg_req.sel <= s;
    repeat (3) @(posedge mclk);
    #1;
    chk(rdata === e, "read back");
  endtask

  // set or clear the fault, then count cycles until output is v
  task automatic go(input logic f, input logic v, input int lim);
    @(posedge mclk);
    vin_mant <= f ? 11'h032 : 11'h0C8;
    #1;
    n = 0;
    while (oe !== v && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  initial begin
    #2000000;
    n_errors++;
    $display("MISMATCH %0t timeout", $time);
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(1'b0, 16'h0000);
    rd(1'b1, 16'h2800);
    wr(1'b1, 16'h0064);
    rd(1'b1, 16'h2864);
    go(1'b1, 1'b0, 60);
    chk(uv === 1'b1 && oe === 1'b1, "ignore mode");
    // fault must clear once so the new setting loads the attempt count
    go(1'b0, 1'b1, 4);
    wr(1'b0, 16'h0088);
    rd(1'b0, 16'h0088);
    chk(left === 3'h1, "attempts loaded");
    go(1'b1, 1'b0, 10);
    chk(n <= 4 && left === 3'h0, "immediate off");
    go(1'b1, 1'b1, 1200);
    chk(n >= 1006 && n <= 1014, "restart spacing");
    repeat (8) @(posedge mclk);
    #1;
    chk(lat === 1'b1 && oe === 1'b0, "latched off");
    @(posedge mclk);
    bias <= 1'b0;
    go(1'b0, 1'b1, 8);
    chk(lat === 1'b0, "bias loss clears");
    @(posedge mclk);
    bias <= 1'b1;
    go(1'b0, 1'b1, 10);
    chk(oe === 1'b1, "restart after clear");
    wr(1'b0, 16'h0079);
    go(1'b1, 1'b0, 200);
    chk(n >= 80 && n <= 86, "first delay");
    repeat (7000) @(posedge mclk);
    go(1'b0, 1'b1, 2400);
    repeat (6) @(posedge mclk);
    #1;
    chk(lat === 1'b0 && left === 3'h7, "unlimited retries");
    wr(1'b0, 16'h00C0);
    go(1'b1, 1'b0, 10);
    repeat (100) @(posedge mclk);
    #1;
    chk(oe === 1'b0, "wait for clear");
    go(1'b0, 1'b1, 10);
    chk(oe === 1'b1, "on after clear");
    wr(1'b0, 16'h0080);
    go(1'b1, 1'b0, 10);
    repeat (8) @(posedge mclk);
    #1;
    chk(lat === 1'b1, "zero retries latch");
    @(posedge mclk);
    pwr <= 1'b0;
    go(1'b0, 1'b1, 8);
    chk(lat === 1'b0 && oe === 1'b0, "power cycle clears");
    @(posedge mclk);
    pwr <= 1'b1;
    go(1'b0, 1'b1, 10);
    chk(oe === 1'b1, "power back on");
    go(1'b1, 1'b0, 10);
    chk(lat === 1'b1, "latched before reset");
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(lat === 1'b0 && oe === 1'b0 && rdata === 16'h0000, "reset clears");
    @(posedge mclk);
    sys_rst <= 1'b0;
    // registers are back to ignore mode and a zero threshold
    go(1'b1, 1'b1, 10);
    chk(oe === 1'b1 && uv === 1'b0 && lat === 1'b0, "on after reset");
    report_and_stop();
  end
endmodule
